// File: shared/ppr_pkg.sv
// package: register map, field layout and pin tables for the pin route select
// Overview of operation
// - event G on G2, or G7 when set
// - event F on F2; set gives no pin
// - event E on E2, or E7 when set
// - event D on D2, or D7 when set
// - event C on C2, or C7 when set
// - event B on B2, or B7 when set
// - event A on A2, or A7 when set
// - cell 5 out G3/G6, inputs G0-G2
// - cell 4 out B3/B6, inputs B0-B2
// - cell 3 on F0-F3; set disconnects
// - cell 2 out D3/D6, inputs D0-D2
// - cell 1 out C3/C6, inputs C0-C2
// - cell 0 out A3/A6, inputs A0-A2
// - serial 3 on B0-3, B4-7 or none
// - serial 2 F0-3, F4-5 only, or none
// - serial 1 on C0-3, C4-7 or none
// - serial 0 on A0-3, A4-7 or none
// - serial 5 on G0-3, G4-7 or none
// - serial 4 on E0-3, E4-7 or none
package ppr_pkg;
  // register indices; byte address is four times the index
  localparam logic [1:0] EV_ROUTE_IDX = 2'h0;
  localparam logic [1:0] LC_ROUTE_IDX = 2'h1;
  localparam logic [1:0] SER_LOW_IDX = 2'h2;
  localparam logic [1:0] SER_HIGH_IDX = 2'h3;
  // reset values
  localparam logic [7:0] EV_ROUTE_RST = 8'h00;
  localparam logic [7:0] LC_ROUTE_RST = 8'h00;
  localparam logic [7:0] SER_LOW_RST = 8'h00;
  localparam logic [7:0] SER_HIGH_RST = 8'h00;
  // implemented bits per register
  localparam logic [7:0] EV_ROUTE_MASK = 8'h7F;
  localparam logic [7:0] LC_ROUTE_MASK = 8'h3F;
  localparam logic [7:0] SER_LOW_MASK = 8'hFF;
  localparam logic [7:0] SER_HIGH_MASK = 8'h0F;
  // port numbering, A..G
  localparam int PORT_A = 0;
  localparam int PORT_B = 1;
  localparam int PORT_C = 2;
  localparam int PORT_D = 3;
  localparam int PORT_E = 4;
  localparam int PORT_F = 5;
  localparam int PORT_G = 6;
  localparam int NUM_PORTS = 7;
  localparam int NUM_EVENTS = 7;
  localparam int NUM_CELLS = 6;
  localparam int NUM_SERIAL = 6;
  // pin positions
  localparam int EV_PIN_DEF = 2;
  localparam int EV_PIN_ALT = 7;
  localparam int LC_OUT_DEF = 3;
  localparam int LC_OUT_ALT = 6;
  localparam int SER_BASE_DEF = 0;
  localparam int SER_BASE_ALT = 4;
  // event output F has no alternate pin
  localparam int EV_NO_ALT = 5;
  // logic cell 3 has no alternate placement
  localparam int LC_NO_ALT = 3;
  // serial unit 2 alternate carries transmit and receive only
  localparam int SER_TWO_WIRE = 2;
  // port of each logic cell, cell 0 first
  localparam int LC_PORT [NUM_CELLS] = '{PORT_A, PORT_C, PORT_D, PORT_F, PORT_B, PORT_G};
  // port of each serial unit, unit 0 first
  localparam int SER_PORT [NUM_SERIAL] = '{PORT_A, PORT_C, PORT_F, PORT_B, PORT_E, PORT_G};
  // two-bit serial field values
  localparam logic [1:0] SER_DEFAULT = 2'h0;
  localparam logic [1:0] SER_ALT_ONE = 2'h1;
  localparam logic [1:0] SER_RESERVED = 2'h2;
  localparam logic [1:0] SER_NONE = 2'h3;
  // signals from a serial unit toward the pins
  typedef struct packed {
    logic tx;
    logic xck_o;
    logic xck_oe;
    logic transceiver_direction_line;
  } ppr_ser_out_s;
  // signals from the pins toward a serial unit
  typedef struct packed {
    logic rx;
    logic xck_i;
  } ppr_ser_in_s;
endpackage : ppr_pkg

// File: rtl/ppr_route.sv
// module: peripheral pin route select with its avalon-mm register slave
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
module ppr_route #(
  parameter int ADDR_W = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [ppr_pkg::NUM_EVENTS-1:0] ev_out,
  input wire logic [ppr_pkg::NUM_CELLS-1:0] lc_out,
  output logic [ppr_pkg::NUM_CELLS-1:0][2:0] lc_in,
  input wire ppr_pkg::ppr_ser_out_s [ppr_pkg::NUM_SERIAL-1:0] ser_o,
  output ppr_pkg::ppr_ser_in_s [ppr_pkg::NUM_SERIAL-1:0] ser_i,
  input wire logic [ppr_pkg::NUM_PORTS-1:0][7:0] pin_in,
  output logic [ppr_pkg::NUM_PORTS-1:0][7:0] pin_out,
  output logic [ppr_pkg::NUM_PORTS-1:0][7:0] pin_own
);

  // routing registers
  logic [7:0] event_output_route;
  logic [7:0] logic_cell_route;
  logic [7:0] serial_route_low;
  logic [7:0] serial_route_high;
  // bus decode
  logic [1:0] reg_idx; // word index
  logic aligned; // low address bits zero and in range
  logic take_wr; // write completes at this edge
  logic [7:0] rd_byte; // selected register value
  // next pin and peripheral values
  logic [ppr_pkg::NUM_PORTS-1:0][7:0] next_pin_out;
  logic [ppr_pkg::NUM_PORTS-1:0][7:0] next_pin_own;
  logic [ppr_pkg::NUM_CELLS-1:0][2:0] next_lc_in;
  ppr_pkg::ppr_ser_in_s [ppr_pkg::NUM_SERIAL-1:0] next_ser_i;
  // per-unit serial field
  logic [ppr_pkg::NUM_SERIAL-1:0][1:0] ser_sel;

  assign reg_idx = address[3:2];
  // shift keeps the check legal when the bus is exactly four bits wide
  assign aligned = (address[1:0] == 2'h0) && ((address >> 4) == '0);
  assign take_wr = write && !waitrequest && aligned && byteenable[0];
  // field split; unit 4 and 5 live in the high register
  assign ser_sel = {serial_route_high[3:2], serial_route_high[1:0],
                    serial_route_low[7:6], serial_route_low[5:4],
                    serial_route_low[3:2], serial_route_low[1:0]};

  // one wait state per access: answer on the edge after the request appears
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      waitrequest <= 1'b1;
    end else if ((read || write) && waitrequest) begin
      waitrequest <= 1'b0;
    end else begin
      // back high so the next request gets a fresh wait state
      waitrequest <= 1'b1;
    end
  end

  // read mux; unmapped addresses read as zero
  always_comb begin
    rd_byte = 8'h00;
    if (!aligned) begin
      rd_byte = 8'h00;
    end else if (reg_idx == ppr_pkg::EV_ROUTE_IDX) begin
      rd_byte = event_output_route;
    end else if (reg_idx == ppr_pkg::LC_ROUTE_IDX) begin
      rd_byte = logic_cell_route;
    end else if (reg_idx == ppr_pkg::SER_LOW_IDX) begin
      rd_byte = serial_route_low;
    end else begin
      rd_byte = serial_route_high;
    end
  end

  // read data loaded during the wait state, so it stands at the taking edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      readdata <= 32'h0000_0000;
    end else if (read && waitrequest) begin
      readdata <= {24'h00_0000, rd_byte};
    end
  end

  // register writes; masks keep unused bits at zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      event_output_route <= ppr_pkg::EV_ROUTE_RST;
      logic_cell_route <= ppr_pkg::LC_ROUTE_RST;
      serial_route_low <= ppr_pkg::SER_LOW_RST;
      serial_route_high <= ppr_pkg::SER_HIGH_RST;
    end else if (take_wr) begin
      if (reg_idx == ppr_pkg::EV_ROUTE_IDX) begin
        event_output_route <= writedata[7:0] & ppr_pkg::EV_ROUTE_MASK;
      end else if (reg_idx == ppr_pkg::LC_ROUTE_IDX) begin
        logic_cell_route <= writedata[7:0] & ppr_pkg::LC_ROUTE_MASK;
      end else if (reg_idx == ppr_pkg::SER_LOW_IDX) begin
        serial_route_low <= writedata[7:0] & ppr_pkg::SER_LOW_MASK;
      end else begin
        serial_route_high <= writedata[7:0] & ppr_pkg::SER_HIGH_MASK;
      end
    end
  end

  // routing network; later stages win where two owners share a pin,
  // which already happens at the reset placements, where serial pins 2 and 3 overlap the event and cell pins
  always_comb begin
    int p;
    int b;
    p = 0;
    b = 0;
    next_pin_out = '0;
    next_pin_own = '0;
    next_lc_in = '0;
    next_ser_i = '0;
    // event outputs: port k carries event k
    for (int k = 0; k < ppr_pkg::NUM_EVENTS; k++) begin
      if (!event_output_route[k]) begin
        next_pin_out[k][ppr_pkg::EV_PIN_DEF] = ev_out[k];
        next_pin_own[k][ppr_pkg::EV_PIN_DEF] = 1'b1;
      end else if (k != ppr_pkg::EV_NO_ALT) begin
        // event F with its bit set skips this branch and reaches no pin
        next_pin_out[k][ppr_pkg::EV_PIN_ALT] = ev_out[k];
        next_pin_own[k][ppr_pkg::EV_PIN_ALT] = 1'b1;
      end
    end
    // logic cells: inputs on pins 0..2, output on 3 or 6
    for (int c = 0; c < ppr_pkg::NUM_CELLS; c++) begin
      p = ppr_pkg::LC_PORT[c];
      if (c == ppr_pkg::LC_NO_ALT && logic_cell_route[c]) begin
        // undefined placement: cell cut off entirely
        next_lc_in[c] = 3'h0;
      end else begin
        next_lc_in[c] = pin_in[p][2:0];
        b = logic_cell_route[c] ? ppr_pkg::LC_OUT_ALT : ppr_pkg::LC_OUT_DEF;
        next_pin_out[p][b] = lc_out[c];
        next_pin_own[p][b] = 1'b1;
      end
    end
    // serial units: tx, rx, clock, direction on base+0..3
    for (int u = 0; u < ppr_pkg::NUM_SERIAL; u++) begin
      p = ppr_pkg::SER_PORT[u];
      b = (ser_sel[u] == ppr_pkg::SER_ALT_ONE) ? ppr_pkg::SER_BASE_ALT
                                                : ppr_pkg::SER_BASE_DEF;
      // reserved value treated as disconnected
      if (ser_sel[u] == ppr_pkg::SER_DEFAULT || ser_sel[u] == ppr_pkg::SER_ALT_ONE) begin
        next_pin_out[p][b] = ser_o[u].tx;
        next_pin_own[p][b] = 1'b1;
        next_pin_own[p][b+1] = 1'b0;
        next_ser_i[u].rx = pin_in[p][b+1];
        if (!(u == ppr_pkg::SER_TWO_WIRE && ser_sel[u] == ppr_pkg::SER_ALT_ONE)) begin
          // clock pin is driven only while the unit is clock master
          next_pin_out[p][b+2] = ser_o[u].xck_o;
          next_pin_own[p][b+2] = ser_o[u].xck_oe;
          next_ser_i[u].xck_i = pin_in[p][b+2];
          next_pin_out[p][b+3] = ser_o[u].transceiver_direction_line;
          next_pin_own[p][b+3] = 1'b1;
        end
      end
    end
  end

  // all pin and peripheral outputs registered: one cycle of latency
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pin_out <= '0;
      pin_own <= '0;
    end else begin
      pin_out <= next_pin_out;
      pin_own <= next_pin_own;
    end
  end

  // peripheral-facing inputs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lc_in <= '0;
      ser_i <= '0;
    end else begin
      lc_in <= next_lc_in;
      ser_i <= next_ser_i;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // a request that finds the slave idle is answered on the next edge
  sequence s_req_start;
    (read || write) && waitrequest;
  endsequence
  sequence s_ev_write;
    write && !waitrequest && aligned && byteenable[0] && reg_idx == ppr_pkg::EV_ROUTE_IDX;
  endsequence
  sequence s_hi_write;
    write && !waitrequest && aligned && byteenable[0] && reg_idx == ppr_pkg::SER_HIGH_IDX;
  endsequence

  a_bus_one_wait: assert property (s_req_start |=> !waitrequest ##1 waitrequest)
    else $error("wait state not one cycle");
  a_ev_write_mask: assert property (s_ev_write |=> event_output_route ==
      ($past(writedata[7:0]) & 8'h7F))
    else $error("event route write wrong");
  a_hi_write_mask: assert property (s_hi_write |=> serial_route_high[7:4] == 4'h0 &&
      serial_route_high[3:0] == $past(writedata[3:0]))
    else $error("serial high write wrong");
  a_evd_default: assert property (!event_output_route[3] |=> pin_own[3][2] &&
      pin_out[3][2] == $past(ev_out[3]))
    else $error("event d default pin wrong");
  a_evd_alt: assert property (event_output_route[3] |=> pin_own[3][7] && !pin_own[3][2])
    else $error("event d alternate pin wrong");
  a_evf_no_alt: assert property (event_output_route[5] && ser_sel[2] != 2'h0
      |=> !pin_own[5][2] && !pin_own[5][7])
    else $error("event f driven with bit set");
  a_cell2_route: assert property (logic_cell_route[2] |=> pin_own[3][6] &&
      pin_out[3][6] == $past(lc_out[2]) && lc_in[2] == $past(pin_in[3][2:0]))
    else $error("cell 2 alternate route wrong");
  a_ser1_none: assert property (ser_sel[1] == 2'h3 |=> pin_own[2][1:0] == 2'h0 &&
      ser_i[1].rx == 1'b0)
    else $error("serial 1 not cut off");
  a_ser1_default: assert property (ser_sel[1] == 2'h0 |=> pin_own[2][0] &&
      pin_out[2][0] == $past(ser_o[1].tx) && ser_i[1].rx == $past(pin_in[2][1]))
    else $error("serial 1 default route wrong");
  a_ser2_two_wire: assert property (ser_sel[2] == 2'h1 |=> pin_own[5][4] &&
      ser_i[2].rx == $past(pin_in[5][5]) && ser_i[2].xck_i == 1'b0)
    else $error("serial 2 alternate route wrong");

  // event outputs; serial owner of the same port held off so it cannot mask the pin
  a_evg_default: assert property (!event_output_route[6] && ser_sel[5][1] |=> pin_own[6][2] &&
      pin_out[6][2] == $past(ev_out[6]))
    else $error("event g default pin wrong");
  a_evg_alt: assert property (event_output_route[6] && ser_sel[5][1] |=> pin_own[6][7] &&
      !pin_own[6][2] && pin_out[6][7] == $past(ev_out[6]))
    else $error("event g alternate pin wrong");
  a_evf_default: assert property (!event_output_route[5] && ser_sel[2][1] |=> pin_own[5][2] &&
      pin_out[5][2] == $past(ev_out[5]))
    else $error("event f default pin wrong");
  a_eve_default: assert property (!event_output_route[4] && ser_sel[4][1] |=> pin_own[4][2] &&
      pin_out[4][2] == $past(ev_out[4]))
    else $error("event e default pin wrong");
  a_eve_alt: assert property (event_output_route[4] && ser_sel[4][1] |=> pin_own[4][7] &&
      !pin_own[4][2] && pin_out[4][7] == $past(ev_out[4]))
    else $error("event e alternate pin wrong");
  a_evc_default: assert property (!event_output_route[2] && ser_sel[1][1] |=> pin_own[2][2] &&
      pin_out[2][2] == $past(ev_out[2]))
    else $error("event c default pin wrong");
  a_evc_alt: assert property (event_output_route[2] && ser_sel[1][1] |=> pin_own[2][7] &&
      !pin_own[2][2] && pin_out[2][7] == $past(ev_out[2]))
    else $error("event c alternate pin wrong");
  a_evb_default: assert property (!event_output_route[1] && ser_sel[3][1] |=> pin_own[1][2] &&
      pin_out[1][2] == $past(ev_out[1]))
    else $error("event b default pin wrong");
  a_evb_alt: assert property (event_output_route[1] && ser_sel[3][1] |=> pin_own[1][7] &&
      !pin_own[1][2] && pin_out[1][7] == $past(ev_out[1]))
    else $error("event b alternate pin wrong");
  a_eva_default: assert property (!event_output_route[0] && ser_sel[0][1] |=> pin_own[0][2] &&
      pin_out[0][2] == $past(ev_out[0]))
    else $error("event a default pin wrong");
  a_eva_alt: assert property (event_output_route[0] && ser_sel[0][1] |=> pin_own[0][7] &&
      !pin_own[0][2] && pin_out[0][7] == $past(ev_out[0]))
    else $error("event a alternate pin wrong");

  // logic cells; inputs follow the port pins whatever the output placement, except cell 3 with its bit set, whose inputs read zero
  a_cell5_default: assert property (!logic_cell_route[5] && ser_sel[5][1] |=> pin_own[6][3] &&
      pin_out[6][3] == $past(lc_out[5]) && lc_in[5] == $past(pin_in[6][2:0]))
    else $error("cell 5 default route wrong");
  a_cell5_alt: assert property (logic_cell_route[5] && ser_sel[5][1] |=> pin_own[6][6] &&
      pin_out[6][6] == $past(lc_out[5]) && lc_in[5] == $past(pin_in[6][2:0]))
    else $error("cell 5 alternate route wrong");
  a_cell4_default: assert property (!logic_cell_route[4] && ser_sel[3][1] |=> pin_own[1][3] &&
      pin_out[1][3] == $past(lc_out[4]) && lc_in[4] == $past(pin_in[1][2:0]))
    else $error("cell 4 default route wrong");
  a_cell4_alt: assert property (logic_cell_route[4] && ser_sel[3][1] |=> pin_own[1][6] &&
      pin_out[1][6] == $past(lc_out[4]) && lc_in[4] == $past(pin_in[1][2:0]))
    else $error("cell 4 alternate route wrong");
  a_cell3_default: assert property (!logic_cell_route[3] && ser_sel[2][1] |=> pin_own[5][3] &&
      pin_out[5][3] == $past(lc_out[3]) && lc_in[3] == $past(pin_in[5][2:0]))
    else $error("cell 3 default route wrong");
  a_cell3_cut: assert property (logic_cell_route[3] && ser_sel[2][1] |=> !pin_own[5][3] &&
      !pin_own[5][6] && lc_in[3] == 3'h0)
    else $error("cell 3 not cut off");
  a_cell2_default: assert property (!logic_cell_route[2] |=> pin_own[3][3] &&
      pin_out[3][3] == $past(lc_out[2]) && lc_in[2] == $past(pin_in[3][2:0]))
    else $error("cell 2 default route wrong");
  a_cell1_default: assert property (!logic_cell_route[1] && ser_sel[1][1] |=> pin_own[2][3] &&
      pin_out[2][3] == $past(lc_out[1]) && lc_in[1] == $past(pin_in[2][2:0]))
    else $error("cell 1 default route wrong");
  a_cell1_alt: assert property (logic_cell_route[1] && ser_sel[1][1] |=> pin_own[2][6] &&
      pin_out[2][6] == $past(lc_out[1]) && lc_in[1] == $past(pin_in[2][2:0]))
    else $error("cell 1 alternate route wrong");
  a_cell0_default: assert property (!logic_cell_route[0] && ser_sel[0][1] |=> pin_own[0][3] &&
      pin_out[0][3] == $past(lc_out[0]) && lc_in[0] == $past(pin_in[0][2:0]))
    else $error("cell 0 default route wrong");
  a_cell0_alt: assert property (logic_cell_route[0] && ser_sel[0][1] |=> pin_own[0][6] &&
      pin_out[0][6] == $past(lc_out[0]) && lc_in[0] == $past(pin_in[0][2:0]))
    else $error("cell 0 alternate route wrong");

  // serial units; tx, direction and the sampled clock at the chosen base
  a_ser3_alt: assert property (ser_sel[3] == 2'h1 |=> pin_own[1][4] && pin_own[1][7] &&
      pin_out[1][4] == $past(ser_o[3].tx) && ser_i[3].rx == $past(pin_in[1][5]))
    else $error("serial 3 alternate route wrong");
  a_ser3_default: assert property (ser_sel[3] == 2'h0 |=> pin_own[1][3] &&
      pin_out[1][3] == $past(ser_o[3].transceiver_direction_line) && ser_i[3].xck_i == $past(pin_in[1][2]))
    else $error("serial 3 default route wrong");
  a_ser2_default: assert property (ser_sel[2] == 2'h0 |=> pin_own[5][0] &&
      pin_out[5][0] == $past(ser_o[2].tx) && ser_i[2].rx == $past(pin_in[5][1]))
    else $error("serial 2 default route wrong");
  a_ser0_alt: assert property (ser_sel[0] == 2'h1 |=> pin_own[0][4] && pin_own[0][7] &&
      pin_out[0][4] == $past(ser_o[0].tx) && ser_i[0].rx == $past(pin_in[0][5]))
    else $error("serial 0 alternate route wrong");
  a_ser0_cut: assert property (ser_sel[0][1] |=> !pin_own[0][0] && !pin_own[0][4] &&
      ser_i[0] == '0)
    else $error("serial 0 not cut off");
  a_ser5_default: assert property (ser_sel[5] == 2'h0 |=> pin_own[6][0] && pin_own[6][3] &&
      pin_out[6][0] == $past(ser_o[5].tx) && ser_i[5].rx == $past(pin_in[6][1]))
    else $error("serial 5 default route wrong");
  a_ser4_alt: assert property (ser_sel[4] == 2'h1 |=> pin_own[4][4] && pin_own[4][7] &&
      pin_out[4][4] == $past(ser_o[4].tx) && ser_i[4].rx == $past(pin_in[4][5]))
    else $error("serial 4 alternate route wrong");
  a_ser4_cut: assert property (ser_sel[4][1] |=> !pin_own[4][0] && !pin_own[4][4] &&
      ser_i[4] == '0)
    else $error("serial 4 not cut off");

  // cell register keeps its two unused bits at zero
  a_lc_mask: assert property (logic_cell_route[7:6] == 2'h0)
    else $error("cell route unused bits set");

endmodule : ppr_route

// File: dv/ppr_route_tb_top.sv
// testbench: register bus and pin routing checks for the pin route select
`timescale 1ns/1ps
module ppr_route_tb_top;
  logic ref_clk; // 20 MHz system clock
  logic rst; // async reset, active high
  logic [3:0] address;
  logic read;
  logic write;
  logic [3:0] byteenable;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  logic [6:0] ev_out; // event outputs, bit 0 is A
  logic [5:0] lc_out; // logic cell outputs
  logic [5:0][2:0] lc_in;
  ppr_pkg::ppr_ser_out_s [5:0] ser_o;
  ppr_pkg::ppr_ser_in_s [5:0] ser_i;
  logic [6:0][7:0] pin_in;
  logic [6:0][7:0] pin_out;
  logic [6:0][7:0] pin_own;
  int n_errors; // mismatches seen
  int checks_done; // comparisons made
  logic [31:0] q; // last read data

  ppr_route dut (.ref_clk(ref_clk), .rst(rst), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .ev_out(ev_out), .lc_out(lc_out), .lc_in(lc_in),
    .ser_o(ser_o), .ser_i(ser_i), .pin_in(pin_in), .pin_out(pin_out), .pin_own(pin_own));

  // free-running clock, 50 ns period
  always #25 ref_clk = ~ref_clk;

  // verdict and end of run, also reached from a hung bus wait
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  // one comparison; case equality so unknowns never match
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one avalon transfer; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                     input logic [3:0] be, output logic [31:0] rd);
    int n;
    @(posedge ref_clk);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= {24'h0, d};
    byteenable <= be;
    n = 0;
    // bounded wait: a stuck slave must not hang the run
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      n_errors++;
      $display("wrong value at %0t: bus never answered", $time);
      tally_and_finish();
    end
  endtask : bus

  // write helper, then let the routing follow the register
  task automatic wr_settle(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF, q);
    repeat (3) @(posedge ref_clk);
  endtask : wr_settle

  // reset values, masks, ignored byte lane, unmapped place
  task automatic t_regs();
    logic [7:0] m [4];
    m = '{8'h7F, 8'h3F, 8'hFF, 8'h0F};
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 4'(i * 4), 8'h00, 4'hF, q);
      chk(q, 32'h0);
      bus(1'b1, 4'(i * 4), 8'hFF, 4'hF, q);
      bus(1'b0, 4'(i * 4), 8'h00, 4'hF, q);
      chk(q, {24'h0, m[i]});
    end
    // write with byte lane 0 off must leave the register alone
    bus(1'b1, 4'h0, 8'h00, 4'hE, q);
    bus(1'b0, 4'h0, 8'h00, 4'hF, q);
    chk(q, 32'h7F);
    bus(1'b0, 4'h1, 8'h00, 4'hF, q);
    chk(q, 32'h0);
  endtask : t_regs

  // event outputs on default then alternate pins
  task automatic t_events();
    int pin;
    wr_settle(4'h8, 8'hFF); // serial units off the pins
    wr_settle(4'hC, 8'h0F);
    wr_settle(4'h4, 8'h00);
    for (int s = 0; s < 2; s++) begin
      ev_out <= s ? 7'h2A : 7'h55;
      wr_settle(4'h0, s ? 8'h7F : 8'h00);
      pin = s ? 7 : 2;
      for (int p = 0; p < 7; p++) begin
        if (s == 1 && p == 5) begin
          chk(pin_own[5][2] | pin_own[5][7], 0);
        end else begin
          chk(pin_own[p][pin], 1);
          chk(pin_out[p][pin], ev_out[p]);
          if (s == 1) chk(pin_own[p][2], 0);
        end
      end
    end
  endtask : t_events

  // logic cell outputs and inputs, default then alternate
  task automatic t_cells();
    int pt;
    int pin;
    // distinct low bits per port catch a cell wired to the wrong port
    for (int p = 0; p < 7; p++) pin_in[p] <= 8'(p + 1);
    wr_settle(4'h0, 8'h00);
    for (int s = 0; s < 2; s++) begin
      lc_out <= s ? 6'h2A : 6'h15;
      wr_settle(4'h4, s ? 8'h3F : 8'h00);
      pin = s ? 6 : 3;
      for (int c = 0; c < 6; c++) begin
        pt = ppr_pkg::LC_PORT[c];
        if (s == 1 && c == 3) begin
          chk(pin_own[pt][3] | pin_own[pt][6], 0);
          chk(lc_in[3], 0);
        end else begin
          chk(pin_own[pt][pin], 1);
          chk(pin_out[pt][pin], lc_out[c]);
          chk(lc_in[c], pin_in[pt][2:0]);
        end
      end
    end
  endtask : t_cells

  // every serial field value for every unit
  task automatic t_serial();
    int pt;
    int b;
    for (int u = 0; u < 6; u++) ser_o[u] <= 4'b1010; // tx 1, clk 0, clk oe 1, dir 0
    for (int p = 0; p < 7; p++) pin_in[p] <= 8'h5A; // rx and clock bits always differ
    wr_settle(4'h0, 8'h00);
    wr_settle(4'h4, 8'h00);
    for (int v = 0; v < 4; v++) begin
      wr_settle(4'h8, {4{2'(v)}});
      wr_settle(4'hC, {4'h0, 2'(v), 2'(v)});
      b = v * 4;
      for (int u = 0; u < 6; u++) begin
        pt = ppr_pkg::SER_PORT[u];
        if (v >= 2) begin
          chk(ser_i[u], 0);
          chk(pin_own[pt][0] | pin_own[pt][4], 0);
        end else if (u == 2 && v == 1) begin
          chk({pin_own[5][7:4], pin_out[5][4]}, 5'b00011);
          chk(ser_i[2], {pin_in[5][5], 1'b0});
        end else begin
          chk(pin_own[pt][b+:4], 4'b1101);
          chk(pin_out[pt][b+:4] & 4'b1101, 4'b0001);
          chk(ser_i[u], {pin_in[pt][b+1], pin_in[pt][b+2]});
          chk(pin_own[pt][4-b], 0);
        end
      end
    end
  endtask : t_serial

  // reset, then the scenarios in turn
  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    address = 4'h0;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'h0;
    writedata = 32'h0;
    ev_out = 7'h00;
    lc_out = 6'h00;
    ser_o = '0;
    pin_in = '0;
    n_errors = 0;
    checks_done = 0;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_events();
    t_cells();
    t_serial();
    tally_and_finish();
  end
endmodule : ppr_route_tb_top
